/* bench/testbench.sv */
// Self-checking bench for the two-wire master register block
`timescale 1ns/1ps
module testbench
  import two_wire_pkg::*;
;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic hwrite = 1'b0;
  logic ack_en = 1'b1;
  logic hreadyout, hresp, scl_out, scl_oe, sda_out, sda_oe, irq, pull;
  logic [31:0] hrdata, rv;
  logic [7:0] first_byte, last_byte;
  wire scl = !scl_oe;
  wire sda = !(sda_oe | pull);
  int err_total = 0, tests_run = 0, cyc = 0, lo_n = 0, hi_n = 0, lo_len = 0, hi_len = 0;
  two_wire_master_regs dut_u (.clock(clock), .rst_n(rst_n), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));
  two_wire_slave_model slave_u (.scl(scl), .sda(sda), .ack_en(ack_en), .sda_pull(pull),
    .first_byte(first_byte), .last_byte(last_byte));
  initial forever #2.5 clock = ~clock;
  // Timeout and SCL phase lengths of the last completed low and high
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (scl)
    begin
      hi_n <= hi_n + 1;
      if (lo_n != 0) lo_len <= lo_n;
      lo_n <= 0;
    end
    else
    begin
      lo_n <= lo_n + 1;
      if (hi_n != 0) hi_len <= hi_n;
      hi_n <= 0;
    end
    // Ceiling far above the few thousand cycles the tests need
    if (cyc == 40000)
    begin
      err_total++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("Checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One AHB-Lite single transfer; ready is looked at settled before the edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(negedge clock); while (hreadyout !== 1'b1);
    @(posedge clock);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(negedge clock); while (hreadyout !== 1'b1);
    rv = hrdata;
    @(posedge clock);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rv);
  endtask
  task automatic wait_st(input int b);
    int n;
    n = 0;
    rv = 32'h0;
    while (rv[b] !== 1'b1 && n < 2000)
    begin
      bus(1'b0, OFF_STATUS, 32'h0);
      n++;
    end
    chk("wait_status", 32'h1, {31'h0, rv[b]});
  endtask
  initial
  begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rdc("status", OFF_STATUS, 32'h8);
    rdc("mask", OFF_IRQ_MASK, 32'h0);
    rdc("mode", OFF_MASTER_MODE, 32'h0);
    rdc("reserved", 8'h08, 32'h0);
    chk("pins", 32'h0, {29'h0, hresp, scl_out, sda_out});
    $display("Test reset done");
    bus(1'b1, OFF_CLOCK_WAVEFORM, 32'h0001_0203);
    rdc("waveform", OFF_CLOCK_WAVEFORM, 32'h0001_0203);
    bus(1'b1, OFF_MASTER_MODE, 32'h0050_0000);
    bus(1'b1, OFF_CONTROL, 32'hC);
    rdc("enable_dis", OFF_STATUS, 32'h8);
    bus(1'b1, OFF_CONTROL, 32'h4);
    rdc("enable", OFF_STATUS, 32'hD);
    $display("Test enable done");
    bus(1'b1, OFF_IRQ_ENABLE, 32'h107);
    rdc("mask_en", OFF_IRQ_MASK, 32'h107);
    chk("irq_on", 32'h1, {31'h0, irq});
    bus(1'b1, OFF_IRQ_DISABLE, 32'h6);
    rdc("mask_dis", OFF_IRQ_MASK, 32'h101);
    bus(1'b1, OFF_IRQ_DISABLE, 32'h101);
    // The line follows the mask one register stage later
    repeat (2) @(posedge clock);
    chk("irq_off", 32'h0, {31'h0, irq});
    $display("Test interrupt done");
    bus(1'b1, OFF_TX_HOLDING, 32'h3C);
    bus(1'b0, OFF_STATUS, 32'h0);
    chk("busy", 32'h0, rv & 32'h5);
    wait_st(0);
    chk("addr_w", 32'hA0, {24'h0, first_byte});
    chk("data_w", 32'h3C, {24'h0, last_byte});
    chk("scl_low", 32'd9, 32'(lo_len));
    chk("scl_high", 32'd7, 32'(hi_len));
    $display("Test write done");
    ack_en <= 1'b0;
    bus(1'b1, OFF_TX_HOLDING, 32'h55);
    wait_st(0);
    chk("nack_set", 32'h10D, rv);
    rdc("nack_clr", OFF_STATUS, 32'hD);
    ack_en <= 1'b1;
    // Let the automatic STOP finish; a start written while busy is not taken
    repeat (24) @(posedge clock);
    $display("Test nack done");
    bus(1'b1, OFF_MASTER_MODE, 32'h0050_1100);
    bus(1'b1, OFF_INTERNAL_ADDRESS, 32'h12);
    bus(1'b1, OFF_CONTROL, 32'h3);
    wait_st(1);
    rdc("rx_byte", OFF_RX_HOLDING, 32'hA5);
    wait_st(0);
    chk("rx_clr", 32'h0, rv & 32'h2);
    chk("addr_r", 32'hA1, {24'h0, first_byte});
    $display("Test read done");
    bus(1'b1, OFF_MASTER_MODE, 32'h0050_1000);
    bus(1'b1, OFF_CONTROL, 32'h1);
    wait_st(1);
    bus(1'b1, OFF_CONTROL, 32'h2);
    rdc("rx_first", OFF_RX_HOLDING, 32'hA5);
    wait_st(1);
    rdc("rx_last", OFF_RX_HOLDING, 32'hA5);
    wait_st(0);
    chk("addr_r0", 32'hA1, {24'h0, first_byte});
    $display("Test burst read done");
    bus(1'b1, OFF_IRQ_ENABLE, 32'h1);
    bus(1'b1, OFF_CONTROL, 32'h80);
    @(posedge clock);
    rdc("sr_mode", OFF_MASTER_MODE, 32'h0);
    rdc("sr_mask", OFF_IRQ_MASK, 32'h0);
    rdc("sr_status", OFF_STATUS, 32'h8);
    $display("Test soft reset done");
    complete_run();
  end
endmodule

/* bench/two_wire_slave_model.sv */
// Behavioural two-wire slave: acks on demand, returns a fixed read byte
`timescale 1ns/1ps
module two_wire_slave_model #(parameter logic [7:0] READ_BYTE = 8'hA5)
(
  // Bus lines
  input wire logic scl,
  input wire logic sda,
  // Behaviour and observation
  input wire logic ack_en,
  output logic sda_pull,
  output logic [7:0] first_byte,
  output logic [7:0] last_byte
);
  int bit_n = 0;
  logic rd_q = 1'b0;
  logic first_q = 1'b0;
  logic [7:0] sh_q = 8'h00;
  initial sda_pull = 1'b0;
  // START or repeated start restarts the byte count; the short wait lets an SCL fall
  // in the same step settle, so data moving as SCL drops is not taken for a START
  always @(negedge sda)
  begin
    #1;
    if (scl && !sda)
    begin
      bit_n = 0;
      first_q = 1'b1;
      rd_q = 1'b0;
      sda_pull = 1'b0;
    end
  end
  // Shift in the bits on the rising clock, MSB first
  always @(posedge scl)
  begin
    if (bit_n < 8)
      sh_q = {sh_q[6:0], sda};
    bit_n++;
    if (bit_n == 8 && first_q)
      first_byte = sh_q;
    if (bit_n == 8)
      last_byte = sh_q;
  end
  // Drive only while the clock is low, so data never moves under a high clock
  always @(negedge scl)
  begin
    if (bit_n == 8)
    begin
      if (first_q)
        rd_q = sh_q[0];
      sda_pull = (first_q || !rd_q) ? ack_en : 1'b0;
    end
    else if (bit_n == 9)
    begin
      bit_n = 0;
      first_q = 1'b0;
      sda_pull = rd_q ? !READ_BYTE[7] : 1'b0;
    end
    else
      sda_pull = (rd_q && !first_q && bit_n < 8) ? !READ_BYTE[7-bit_n] : 1'b0;
  end
endmodule

/* inc/two_wire_links_if.sv */
// Interfaces between the register slave, the SCL timer and the core
`timescale 1ns/1ps
interface reg_bus_if;
  logic wr;
  logic rd;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport slave_end (output wr, rd, addr, wdata, input rdata);
  modport core_end (input wr, rd, addr, wdata, output rdata);
endinterface

interface scl_timer_if #(parameter int DIV_W = 8, parameter int EXP_W = 3);
  logic run;
  logic high_sel;
  logic done;
  logic [DIV_W-1:0] low_div;
  logic [DIV_W-1:0] high_div;
  logic [EXP_W-1:0] exp;
  modport gen (input run, high_sel, low_div, high_div, exp, output done);
  modport user (output run, high_sel, low_div, high_div, exp, input done);
endinterface

/* inc/two_wire_pkg.sv */
// Register map, field layout and sequencer types of the two-wire master
package two_wire_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_MASTER_MODE = 8'h04;
  localparam logic [7:0] OFF_INTERNAL_ADDRESS = 8'h0C;
  localparam logic [7:0] OFF_CLOCK_WAVEFORM = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h24;
  localparam logic [7:0] OFF_IRQ_DISABLE = 8'h28;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h2C;
  localparam logic [7:0] OFF_RX_HOLDING = 8'h30;
  localparam logic [7:0] OFF_TX_HOLDING = 8'h34;
  // Control register bits
  localparam int CTL_START_BIT = 0;
  localparam int CTL_STOP_BIT = 1;
  localparam int CTL_ENABLE_BIT = 2;
  localparam int CTL_DISABLE_BIT = 3;
  localparam int CTL_SOFT_RESET_BIT = 7;
  // Master mode and clock waveform fields
  localparam int MM_IADDR_SIZE_LSB = 8;
  localparam int MM_READ_DIR_BIT = 12;
  localparam int MM_SLAVE_ADDR_LSB = 16;
  localparam int CW_LOW_LSB = 0;
  localparam int CW_HIGH_LSB = 8;
  localparam int CW_EXP_LSB = 16;
  // Status bit positions and internal flag order
  localparam int ST_TRANSFER_COMPLETE_BIT = 0;
  localparam int ST_RECEIVE_READY_BIT = 1;
  localparam int ST_TRANSMIT_READY_BIT = 2;
  localparam int ST_NACK_BIT = 8;
  localparam logic [31:0] STATUS_FIXED = 32'h0000_0008;
  localparam int FLAG_TRANSFER_COMPLETE = 0;
  localparam int FLAG_RECEIVE_READY = 1;
  localparam int FLAG_TRANSMIT_READY = 2;
  localparam int FLAG_NACK = 3;
  // Waveform and framing constants
  localparam int DIV_OFFSET = 3;
  localparam int BYTE_W = 8;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [7:0] RELEASE_BYTE = 8'hFF;
  localparam logic PIN_LOW = 1'b0;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [2:0] {SQ_IDLE, SQ_START_A, SQ_START_B, SQ_BIT_LO, SQ_BIT_HI,
    SQ_RESTART, SQ_STOP_A, SQ_STOP_B} seq_state_t;
  typedef enum logic [1:0] {BK_ADDR, BK_IADDR, BK_WDATA, BK_RDATA} byte_kind_t;

  // Place the four flags at their status word positions
  function automatic logic [31:0] flags_to_word(input logic [3:0] f);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[ST_TRANSFER_COMPLETE_BIT] = f[FLAG_TRANSFER_COMPLETE];
    w[ST_RECEIVE_READY_BIT] = f[FLAG_RECEIVE_READY];
    w[ST_TRANSMIT_READY_BIT] = f[FLAG_TRANSMIT_READY];
    w[ST_NACK_BIT] = f[FLAG_NACK];
    return w;
  endfunction

  function automatic logic [3:0] word_to_flags(input logic [31:0] w);
    return {w[ST_NACK_BIT], w[ST_TRANSMIT_READY_BIT], w[ST_RECEIVE_READY_BIT], w[ST_TRANSFER_COMPLETE_BIT]};
  endfunction

  // SCL phase length in clock cycles
  function automatic logic [15:0] half_period(input logic [7:0] div, input logic [2:0] e);
    return (16'(div) << e) + 16'(DIV_OFFSET);
  endfunction
endpackage

/* logic/ahb_reg_slave.sv */
// AHB-Lite slave front end producing register strobes
`timescale 1ns/1ps
module ahb_reg_slave
  import two_wire_pkg::*;
  #(parameter int ADDR_W = 8)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // AHB-Lite
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Register side
  reg_bus_if.slave_end rb
);
  logic wr_q;
  logic rd_q;
  logic [ADDR_W-1:0] addr_q;
  logic accept;

  if (ADDR_W < 8 || ADDR_W > 32)
  begin : g_chk
    $error("ADDR_W must cover the register map");
  end

  // Address phase is taken only with hready high; NONSEQ and SEQ both start a transfer
  assign accept = hsel && htrans[1] && hready;
  assign rb.wr = wr_q;
  assign rb.rd = rd_q;
  assign rb.addr = 8'(addr_q);
  assign rb.wdata = hwdata;

  // Reads add one wait state so that hrdata comes from a flop
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      addr_q <= '0;
      hreadyout <= 1'b1;
      hresp <= HRESP_OKAY;
      hrdata <= 32'h0000_0000;
    end
    else
    begin
      wr_q <= accept && hwrite;
      rd_q <= accept && !hwrite;
      if (accept)
        addr_q <= haddr[ADDR_W-1:0];
      hreadyout <= !(accept && !hwrite);
      hresp <= HRESP_OKAY;
      if (rd_q)
        hrdata <= rb.rdata;
    end
  end
endmodule

/* logic/scl_timer.sv */
// Counter that times one SCL low or high phase
`timescale 1ns/1ps
module scl_timer
  import two_wire_pkg::*;
  #(parameter int DIV_W = 8, parameter int EXP_W = 3, parameter int CNT_W = 16)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Timing request and phase end
  scl_timer_if.gen tm
);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] per;

  if (CNT_W < DIV_W + (2 ** EXP_W))
  begin : g_chk
    $error("CNT_W too narrow for the longest phase");
  end

  function automatic logic [CNT_W-1:0] phase_len(input logic [DIV_W-1:0] div, input logic [EXP_W-1:0] e);
    return (CNT_W'(div) << e) + CNT_W'(DIV_OFFSET);
  endfunction

  // Phase length: divider scaled by the exponent, plus the fixed offset
  assign per = tm.high_sel ? phase_len(tm.high_div, tm.exp) : phase_len(tm.low_div, tm.exp);
  assign tm.done = tm.run && (cnt_q == per - 1'b1);

  // Restarts at zero on each phase end so every step lasts exactly per cycles
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= '0;
    else if (!tm.run || tm.done)
      cnt_q <= '0;
    else
      cnt_q <= cnt_q + 1'b1;
  end
endmodule

/* logic/two_wire_master_regs.sv */
// Two-wire master controller with its AHB-Lite register file
// Contract
// - Start bit write begins a frame with START formatted by master mode.
// - In write direction a transmit holding write starts the frame.
// - Stop request in read mode sends STOP after the current byte.
// - A not-acknowledge in read mode makes the device send STOP itself.
// - Write frame ends with STOP once holding and shift registers are empty.
// - Enable bit enables transfers only if disable bit is zero alongside.
// - Disable takes effect only after pending data finishes.
// - Soft reset bit seven resets the block like a system reset.
// - Two-bit size field selects zero to three internal address bytes.
// - Direction bit twelve selects write or read and the R/W bit.
// - Slave address field bits 22:16 is sent to select the slave.
// - Internal address register supplies the selected bytes, low byte too.
// - SCL low lasts low divider shifted by exponent plus three cycles.
// - SCL high lasts high divider shifted by exponent plus three cycles.
// - Transfer complete is zero during a frame, one after STOP or enable; here a not-acknowledge sets it before its STOP is sent.
// - Receive ready sets on a received byte, clears on holding read.
// - Transmit ready clears on holding write, sets on load, nack, enable.
// - Not-acknowledge flag sets with transfer complete, clears on status read.
// - Interrupt enable write ones enable the matching interrupts.
// - Interrupt disable write ones disable the matching interrupts.
// - Interrupt mask reads one for each enabled interrupt.
// - Data line is released and sampled in the ninth pulse for acknowledge.
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ps
module two_wire_master_regs
  import two_wire_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Two-wire pins, open drain
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Interrupt
  output logic irq
);
  reg_bus_if rb ();
  scl_timer_if #(.DIV_W(BYTE_W), .EXP_W(3)) tm ();

  logic srst_q;
  logic core_rst_n;
  logic [1:0] iaddr_size_q;
  logic read_direction_q;
  logic [6:0] slave_address_q;
  logic [23:0] iaddr_q;
  logic [7:0] low_divider_q;
  logic [7:0] high_divider_q;
  logic [2:0] clock_exponent_q;
  logic [3:0] flags_q;
  logic [3:0] imr_q;
  logic [7:0] rhr_q;
  logic [7:0] thr_q;
  logic thr_full_q;
  logic en_q;
  logic dis_pend_q;
  logic stop_req_q;
  seq_state_t state_q, state_d;
  byte_kind_t kind_q, kind_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d;
  logic [1:0] left_q, left_d;
  logic rd_phase_q, rd_phase_d;
  logic ev_rx, ev_take, ev_nack, ev_done;

  // Register strobes
  logic wr_ctl, wr_mm, wr_ia, wr_cw, wr_ier, wr_idr, wr_thr, rd_status, rd_rhr;
  logic start_cmd, stop_cmd, en_set, dis_cmd, go, idle_quiet, byte_end, addr_rw;
  logic [7:0] iaddr_byte;
  logic [3:0] set_v, clr_v;
  logic sda_drive, sda_oe_d;

  ahb_reg_slave #(.ADDR_W(8)) u_bus (
    .clock(clock),
    .rst_n(rst_n),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .rb(rb)
  );

  scl_timer #(.DIV_W(BYTE_W), .EXP_W(3), .CNT_W(16)) u_timer (
    .clock(clock),
    .rst_n(core_rst_n),
    .tm(tm)
  );

  // Soft reset drops the core reset for one cycle; the bus slave stays alive
  assign core_rst_n = rst_n & ~srst_q;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      srst_q <= 1'b0;
    else
      srst_q <= rb.wr && rb.addr == OFF_CONTROL && rb.wdata[CTL_SOFT_RESET_BIT];
  end

  // Address decode; only word-aligned offsets match, others read zero
  assign wr_ctl = rb.wr && rb.addr == OFF_CONTROL;
  assign wr_mm = rb.wr && rb.addr == OFF_MASTER_MODE;
  assign wr_ia = rb.wr && rb.addr == OFF_INTERNAL_ADDRESS;
  assign wr_cw = rb.wr && rb.addr == OFF_CLOCK_WAVEFORM;
  assign wr_ier = rb.wr && rb.addr == OFF_IRQ_ENABLE;
  assign wr_idr = rb.wr && rb.addr == OFF_IRQ_DISABLE;
  assign wr_thr = rb.wr && rb.addr == OFF_TX_HOLDING;
  assign rd_status = rb.rd && rb.addr == OFF_STATUS;
  assign rd_rhr = rb.rd && rb.addr == OFF_RX_HOLDING;

  // Control commands; zero bits do nothing
  assign start_cmd = wr_ctl && rb.wdata[CTL_START_BIT];
  assign stop_cmd = wr_ctl && rb.wdata[CTL_STOP_BIT];
  assign en_set = wr_ctl && rb.wdata[CTL_ENABLE_BIT] && !rb.wdata[CTL_DISABLE_BIT];
  assign dis_cmd = wr_ctl && rb.wdata[CTL_DISABLE_BIT];

  // Frame launch and disable completion
  assign go = en_q && state_q == SQ_IDLE && (start_cmd || (!read_direction_q && thr_full_q));
  assign idle_quiet = state_q == SQ_IDLE && !go && !(thr_full_q && !read_direction_q);
  assign byte_end = state_q == SQ_BIT_HI && tm.done && bit_q == ACK_SLOT;
  // With an internal address a read first addresses the slave for writing
  assign addr_rw = read_direction_q && (iaddr_size_q == 2'h0 || rd_phase_q);
  assign iaddr_byte = iaddr_q[{left_q - 2'h1, 3'h0} +: BYTE_W];

  // Timer hookup: one step of the sequencer lasts one SCL phase
  assign tm.run = state_q != SQ_IDLE;
  assign tm.high_sel = state_q inside {SQ_START_A, SQ_START_B, SQ_BIT_HI, SQ_STOP_B};
  assign tm.low_div = low_divider_q;
  assign tm.high_div = high_divider_q;
  assign tm.exp = clock_exponent_q;

  // Byte and bit sequencer
  always_comb
  begin
    state_d = state_q;
    kind_d = kind_q;
    bit_d = bit_q;
    sh_d = sh_q;
    left_d = left_q;
    rd_phase_d = rd_phase_q;
    ev_rx = 1'b0;
    ev_take = 1'b0;
    ev_nack = 1'b0;
    ev_done = 1'b0;
    unique case (state_q)
      SQ_IDLE:
        if (go)
        begin
          state_d = SQ_START_A;
          left_d = iaddr_size_q;
          rd_phase_d = 1'b0;
        end
      SQ_START_A:
        if (tm.done)
          state_d = SQ_START_B;
      SQ_START_B:
        if (tm.done)
        begin
          state_d = SQ_BIT_LO;
          kind_d = BK_ADDR;
          bit_d = 4'h0;
          sh_d = {slave_address_q, addr_rw};
        end
      SQ_BIT_LO:
        if (tm.done)
          state_d = SQ_BIT_HI;
      SQ_BIT_HI:
        if (tm.done && bit_q != ACK_SLOT)
        begin
          state_d = SQ_BIT_LO;
          bit_d = bit_q + 4'h1;
          sh_d = {sh_q[6:0], sda_in};
        end
        else if (tm.done)
        begin
          state_d = SQ_BIT_LO;
          bit_d = 4'h0;
          if (kind_q == BK_RDATA)
          begin
            ev_rx = 1'b1;
            sh_d = RELEASE_BYTE;
            if (stop_req_q)
              state_d = SQ_STOP_A;
          end
          else if (sda_in)
          begin
            ev_nack = 1'b1;
            state_d = SQ_STOP_A;
          end
          else if (kind_q == BK_ADDR && addr_rw)
          begin
            kind_d = BK_RDATA;
            sh_d = RELEASE_BYTE;
          end
          else if (kind_q != BK_WDATA && left_q != 2'h0)
          begin
            kind_d = BK_IADDR;
            sh_d = iaddr_byte;
            left_d = left_q - 2'h1;
          end
          else if (read_direction_q)
          begin
            state_d = SQ_RESTART;
            rd_phase_d = 1'b1;
          end
          else if (thr_full_q)
          begin
            kind_d = BK_WDATA;
            sh_d = thr_q;
            ev_take = 1'b1;
          end
          else
            state_d = SQ_STOP_A;
        end
      SQ_RESTART:
        if (tm.done)
          state_d = SQ_START_A;
      SQ_STOP_A:
        if (tm.done)
          state_d = SQ_STOP_B;
      SQ_STOP_B:
        if (tm.done)
        begin
          state_d = SQ_IDLE;
          ev_done = 1'b1;
        end
    endcase
  end

  // SDA only changes while SCL is low, except for START and STOP, so a late stop request never makes a false condition
  assign sda_drive = (state_d inside {SQ_START_B, SQ_STOP_A, SQ_STOP_B})
    || (state_d == SQ_BIT_LO && bit_d != ACK_SLOT && !sh_d[7])
    || (state_d == SQ_BIT_LO && bit_d == ACK_SLOT && kind_d == BK_RDATA && !stop_req_q);
  assign sda_oe_d = state_d == SQ_BIT_HI ? sda_oe : sda_drive;

  // Sequencer registers and pin drivers
  always_ff @(posedge clock or negedge core_rst_n)
  begin
    if (!core_rst_n)
    begin
      state_q <= SQ_IDLE;
      kind_q <= BK_ADDR;
      bit_q <= 4'h0;
      sh_q <= RELEASE_BYTE;
      left_q <= 2'h0;
      rd_phase_q <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      scl_out <= PIN_LOW;
      sda_out <= PIN_LOW;
    end
    else
    begin
      state_q <= state_d;
      kind_q <= kind_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      left_q <= left_d;
      rd_phase_q <= rd_phase_d;
      scl_oe <= state_d inside {SQ_BIT_LO, SQ_RESTART, SQ_STOP_A};
      sda_oe <= sda_oe_d;
      scl_out <= PIN_LOW;
      sda_out <= PIN_LOW;
    end
  end

  // Flag events; a set in the same cycle as its clear wins
  assign set_v = {ev_nack, ev_take | ev_nack | en_set, ev_rx, ev_done | ev_nack | en_set};
  assign clr_v = {rd_status, wr_thr, rd_rhr, go};

  // Software-written configuration
  always_ff @(posedge clock or negedge core_rst_n)
  begin
    if (!core_rst_n)
    begin
      {slave_address_q, read_direction_q, iaddr_size_q} <= '0;
      iaddr_q <= 24'h00_0000;
      {clock_exponent_q, high_divider_q, low_divider_q} <= '0;
      imr_q <= 4'h0;
    end
    else
    begin
      if (wr_mm)
        {slave_address_q, read_direction_q, iaddr_size_q} <= {rb.wdata[MM_SLAVE_ADDR_LSB +: 7],
          rb.wdata[MM_READ_DIR_BIT], rb.wdata[MM_IADDR_SIZE_LSB +: 2]};
      if (wr_ia)
        iaddr_q <= rb.wdata[23:0];
      if (wr_cw)
        {clock_exponent_q, high_divider_q, low_divider_q} <= {rb.wdata[CW_EXP_LSB +: 3],
          rb.wdata[CW_HIGH_LSB +: 8], rb.wdata[CW_LOW_LSB +: 8]};
      imr_q <= (imr_q & ~({4{wr_idr}} & word_to_flags(rb.wdata))) | ({4{wr_ier}} & word_to_flags(rb.wdata));
    end
  end

  // Status, holding registers, enable and the interrupt line
  always_ff @(posedge clock or negedge core_rst_n)
  begin
    if (!core_rst_n)
    begin
      flags_q <= 4'h0;
      rhr_q <= 8'h00;
      thr_q <= 8'h00;
      thr_full_q <= 1'b0;
      en_q <= 1'b0;
      dis_pend_q <= 1'b0;
      stop_req_q <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      flags_q <= (flags_q & ~clr_v) | set_v;
      if (ev_rx)
        rhr_q <= sh_q;
      if (wr_thr)
        thr_q <= rb.wdata[7:0];
      thr_full_q <= wr_thr | (thr_full_q & ~ev_take & ~ev_nack); // a refused byte is dropped, no endless retry
      en_q <= en_set | (en_q & ~(dis_pend_q & idle_quiet));
      dis_pend_q <= dis_cmd | (dis_pend_q & en_q & ~en_set);
      stop_req_q <= stop_cmd | (stop_req_q & ~ev_done);
      irq <= |(flags_q & imr_q);
    end
  end

  // Read data selection
  always_comb
  begin
    case (rb.addr)
      OFF_MASTER_MODE:
        rb.rdata = {9'h000, slave_address_q, 3'h0, read_direction_q, 2'h0, iaddr_size_q, 8'h00};
      OFF_INTERNAL_ADDRESS:
        rb.rdata = {8'h00, iaddr_q};
      OFF_CLOCK_WAVEFORM:
        rb.rdata = {13'h0000, clock_exponent_q, high_divider_q, low_divider_q};
      OFF_STATUS:
        rb.rdata = flags_to_word(flags_q) | STATUS_FIXED;
      OFF_IRQ_MASK:
        rb.rdata = flags_to_word(imr_q);
      OFF_RX_HOLDING:
        rb.rdata = {24'h00_0000, rhr_q};
      OFF_TX_HOLDING:
        rb.rdata = {24'h00_0000, thr_q};
      default:
        rb.rdata = 32'h0000_0000;
    endcase
  end

  // Checks on the sequencer, flags and waveform
  logic [15:0] lo_cnt_q, st_cnt_q;
  always_ff @(posedge clock or negedge core_rst_n)
  begin
    if (!core_rst_n)
    begin
      lo_cnt_q <= 16'h0000;
      st_cnt_q <= 16'h0000;
    end
    else
    begin
      lo_cnt_q <= scl_oe ? lo_cnt_q + 16'h0001 : 16'h0000;
      st_cnt_q <= state_d != state_q ? 16'h0000 : st_cnt_q + 16'h0001;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!core_rst_n);

  sequence tx_nacked;
    byte_end && kind_q != BK_RDATA && sda_in;
  endsequence
  sequence stop_entered;
    state_q == SQ_STOP_A ##1 (state_q == SQ_STOP_A)[*2];
  endsequence

  start_frame_a: assert property (go |=> state_q == SQ_START_A ##1 state_q == SQ_START_A)
    else $error("frame did not begin with START");
  thr_launch_a: assert property (en_q && state_q == SQ_IDLE && !read_direction_q && thr_full_q
    |=> state_q == SQ_START_A)
    else $error("holding write did not launch a frame");
  read_stop_a: assert property (byte_end && kind_q == BK_RDATA && stop_req_q |=> stop_entered)
    else $error("requested stop not sent after read byte");
  nack_stop_a: assert property (tx_nacked |=> stop_entered)
    else $error("no automatic stop after not-acknowledge");
  nack_flags_a: assert property (tx_nacked |=> flags_q[FLAG_NACK] && flags_q[FLAG_TRANSFER_COMPLETE] && flags_q[FLAG_TRANSMIT_READY])
    else $error("not-acknowledge flags not set together");
  write_stop_a: assert property (byte_end && kind_q == BK_WDATA && !sda_in && !thr_full_q
    |=> state_q == SQ_STOP_A)
    else $error("empty write did not end with stop");
  enable_flags_a: assert property (en_set |=> en_q && flags_q[FLAG_TRANSFER_COMPLETE] && flags_q[FLAG_TRANSMIT_READY])
    else $error("enable did not set ready flags");
  scl_low_len_a: assert property ($fell(scl_oe) |-> lo_cnt_q == half_period(low_divider_q, clock_exponent_q))
    else $error("SCL low phase has wrong length");
  scl_high_len_a: assert property (state_q == SQ_BIT_HI && state_d != SQ_BIT_HI
    |-> st_cnt_q + 16'h0001 == half_period(high_divider_q, clock_exponent_q))
    else $error("SCL high phase has wrong length");
  rx_ready_a: assert property (ev_rx |=> flags_q[FLAG_RECEIVE_READY] && rhr_q == $past(sh_q))
    else $error("received byte not posted");
  thr_clear_a: assert property (wr_thr && !ev_take && !ev_nack && !en_set |=> !flags_q[FLAG_TRANSMIT_READY])
    else $error("transmit ready not cleared by holding write");
  irq_out_a: assert property (|(flags_q & imr_q) |=> irq)
    else $error("interrupt not raised for enabled flag");
endmodule
